// >>> hdl/acu_adc_control.sv
`timescale 1ns/10ps
module acu_adc_control
  import acu_pkg::*;
#(
  parameter int CLKS_PER_BIT = ACU_CLKS_PER_BIT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_cmp_gt,
  input wire logic i_timer_clk_en,
  input wire logic i_comparator_out_en,
  input wire logic i_sleep,
  output logic [9:0] o_dac_code,
  output logic o_sample,
  output logic [6:0] o_pin_analog,
  output logic [2:0] o_mux_sel,
  output logic o_mux_valid,
  output logic o_ref_from_pin,
  output logic o_ref_power,
  output logic [1:0] o_pin5_func,
  output logic [1:0] o_pin4_func,
  output logic o_irq,
  output logic [11:0] o_irq_vector,
  output logic o_wake
);
  acu_state_e state_reg, state_next;
  logic [7:0] pin_sel_reg, pin_sel_next;
  logic [7:0] ctl_reg, ctl_next;
  logic [7:0] ofs_reg, ofs_next;
  logic [9:0] res_reg, res_next;
  logic [9:0] sar_reg, sar_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] div_reg, div_next;
  logic done_reg, done_next;
  logic irq_en_reg, irq_en_next;
  logic wake_en_reg, wake_en_next;
  logic [7:0] rdata_reg, rdata_next;
  logic cmp_s1_reg, cmp_s2_reg;
  logic tick;
  logic running;
  logic finish;
  logic [10:0] corrected;
  logic [10:0] mag_ext;

  assign running = (state_reg != ACU_IDLE);

  acu_prescaler u_prescaler (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_run(running),
    .i_rate(ctl_reg[ACU_CTL_RATE_HI:ACU_CTL_RATE_LO]),
    .o_tick(tick)
  );

  // Comparator comes from the analog core, outside the clock domain
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      cmp_s1_reg <= i_cmp_gt;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // Offset correction with clamping to the ten-bit range
  always_comb begin
    mag_ext = {8'h00, ofs_reg[ACU_OFS_MAG_HI:ACU_OFS_MAG_LO]};
    corrected = {1'b0, sar_reg};
    if (ofs_reg[ACU_OFS_CAL_EN]) begin
      if (ofs_reg[ACU_OFS_SIGN]) begin
        corrected = {1'b0, sar_reg} + mag_ext;
        if (corrected[10]) begin
          corrected = 11'h3FF;
        end
      end else begin
        if ({1'b0, sar_reg} < mag_ext) begin
          corrected = 11'h000;
        end else begin
          corrected = {1'b0, sar_reg} - mag_ext;
        end
      end
    end
  end

  assign finish = (state_reg == ACU_DONE);

  // Register file: bus writes first, then the completion event
  always_comb begin
    pin_sel_next = pin_sel_reg;
    ctl_next = ctl_reg;
    ofs_next = ofs_reg;
    res_next = res_reg;
    done_next = done_reg;
    irq_en_next = irq_en_reg;
    wake_en_next = wake_en_reg;

    if (i_wr) begin
      if (i_addr == ACU_ADDR_PIN_SEL) begin
        pin_sel_next = i_wdata & ACU_PIN_SEL_MASK;
      end else if (i_addr == ACU_ADDR_CONTROL) begin
        ctl_next[7:5] = i_wdata[7:5];
        ctl_next[ACU_CTL_POWER] = i_wdata[ACU_CTL_POWER];
        if (i_wdata[ACU_CTL_RUN]) begin
          ctl_next[ACU_CTL_RUN] = 1'b1;
        end
        if (!done_reg && !ctl_reg[ACU_CTL_RUN]) begin
          ctl_next[ACU_CTL_CH_HI:0] = i_wdata[ACU_CTL_CH_HI:0];
        end
      end else if (i_addr == ACU_ADDR_OFFSET) begin
        ofs_next = i_wdata & ACU_OFS_MASK;
      end else if (i_addr == ACU_ADDR_STATUS) begin
        if (!i_wdata[0]) begin
          done_next = 1'b0;
        end
      end else if (i_addr == ACU_ADDR_ENABLES) begin
        irq_en_next = i_wdata[ACU_EN_IRQ];
        wake_en_next = i_wdata[ACU_EN_WAKE];
      end
    end

    // The done flag wins over a clear in the same cycle; a start written
    // in that cycle wins over the hardware clear of the run bit
    if (finish) begin
      res_next = corrected[9:0];
      done_next = 1'b1;
      if (!(i_wr && i_addr == ACU_ADDR_CONTROL && i_wdata[ACU_CTL_RUN])) begin
        ctl_next[ACU_CTL_RUN] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin_sel_reg <= ACU_RESET_VAL;
      ctl_reg <= ACU_RESET_VAL;
      ofs_reg <= ACU_RESET_VAL;
      res_reg <= 10'h000;
      done_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      wake_en_reg <= 1'b0;
    end else begin
      pin_sel_reg <= pin_sel_next;
      ctl_reg <= ctl_next;
      ofs_reg <= ofs_next;
      res_reg <= res_next;
      done_reg <= done_next;
      irq_en_reg <= irq_en_next;
      wake_en_reg <= wake_en_next;
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      if (i_addr == ACU_ADDR_PIN_SEL) begin
        rdata_next = pin_sel_reg;
      end else if (i_addr == ACU_ADDR_CONTROL) begin
        rdata_next = ctl_reg;
      end else if (i_addr == ACU_ADDR_OFFSET) begin
        rdata_next = ofs_reg;
      end else if (i_addr == ACU_ADDR_RES_HI) begin
        rdata_next = res_reg[9:2];
      end else if (i_addr == ACU_ADDR_RES_LO) begin
        rdata_next = {6'h00, res_reg[1:0]};
      end else if (i_addr == ACU_ADDR_STATUS) begin
        rdata_next = {7'h00, done_reg};
      end else if (i_addr == ACU_ADDR_ENABLES) begin
        rdata_next = {6'h00, wake_en_reg, irq_en_reg};
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Sequencer keeps running whatever the sleep input says
  always_comb begin
    state_next = state_reg;
    sar_next = sar_reg;
    bit_next = bit_reg;
    div_next = div_reg;
    case (state_reg)
      ACU_IDLE: begin
        if (ctl_reg[ACU_CTL_RUN] && ctl_reg[ACU_CTL_POWER]) begin
          state_next = ACU_SAMPLE;
          sar_next = 10'h000;
          bit_next = 4'(ACU_RES_BITS - 1);
          div_next = 8'h00;
        end
      end
      ACU_SAMPLE: begin
        if (tick) begin
          state_next = ACU_BITS;
          sar_next = 10'h200;
        end
      end
      ACU_BITS: begin
        // Ticks are at least four clocks apart, so the synchronised comparator has settled
        if (tick) begin
          if (div_reg == 8'(CLKS_PER_BIT - 1)) begin
            div_next = 8'h00;
            if (!cmp_s2_reg) begin
              sar_next[bit_reg] = 1'b0;
            end
            if (bit_reg == 4'h0) begin
              state_next = ACU_DONE;
            end else begin
              sar_next[bit_reg - 4'h1] = 1'b1;
              bit_next = bit_reg - 4'h1;
            end
          end else begin
            div_next = div_reg + 8'h01;
          end
        end
      end
      default: begin
        state_next = ACU_IDLE;
      end
    endcase
    // Power off abandons a conversion; the run bit stays set
    if (!ctl_reg[ACU_CTL_POWER] && !finish) begin
      state_next = ACU_IDLE;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ACU_IDLE;
      sar_reg <= 10'h000;
      bit_reg <= 4'h0;
      div_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      sar_reg <= sar_next;
      bit_reg <= bit_next;
      div_reg <= div_next;
    end
  end

  // Pin function codes: 0 port, 1 analog or reference, 2 comparator, 3 timer
  always_comb begin
    if (i_timer_clk_en) begin
      o_pin5_func = 2'h3;
    end else if (i_comparator_out_en) begin
      o_pin5_func = 2'h2;
    end else if (pin_sel_reg[5]) begin
      o_pin5_func = 2'h1;
    end else begin
      o_pin5_func = 2'h0;
    end
    if (ctl_reg[ACU_CTL_REF_SEL]) begin
      o_pin4_func = 2'h1;
    end else if (i_timer_clk_en) begin
      o_pin4_func = 2'h3;
    end else begin
      o_pin4_func = 2'h0;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_dac_code = sar_reg;
  assign o_sample = (state_reg == ACU_SAMPLE);
  assign o_pin_analog = pin_sel_reg[6:0];
  assign o_mux_sel = ctl_reg[ACU_CTL_CH_HI:0];
  assign o_mux_valid = (ctl_reg[ACU_CTL_CH_HI:0] != ACU_CH_NONE);
  assign o_ref_from_pin = ctl_reg[ACU_CTL_REF_SEL];
  assign o_ref_power = ctl_reg[ACU_CTL_POWER];
  assign o_irq = done_reg & irq_en_reg;
  assign o_irq_vector = ACU_CONV_VECTOR;
  assign o_wake = done_reg & wake_en_reg & i_sleep;
endmodule

// >>> hdl/acu_pkg.sv
package acu_pkg;
  // Register addresses on the internal register bus
  localparam logic [3:0] ACU_ADDR_PIN_SEL = 4'h8;
  localparam logic [3:0] ACU_ADDR_CONTROL = 4'h9;
  localparam logic [3:0] ACU_ADDR_OFFSET = 4'hA;
  localparam logic [3:0] ACU_ADDR_RES_HI = 4'hB;
  localparam logic [3:0] ACU_ADDR_RES_LO = 4'hC;
  localparam logic [3:0] ACU_ADDR_STATUS = 4'hD;
  localparam logic [3:0] ACU_ADDR_ENABLES = 4'hE;
  // Control register fields
  localparam int ACU_CTL_REF_SEL = 7;
  localparam int ACU_CTL_RATE_HI = 6;
  localparam int ACU_CTL_RATE_LO = 5;
  localparam int ACU_CTL_RUN = 4;
  localparam int ACU_CTL_POWER = 3;
  localparam int ACU_CTL_CH_HI = 2;
  // Offset register fields
  localparam int ACU_OFS_CAL_EN = 7;
  localparam int ACU_OFS_SIGN = 6;
  localparam int ACU_OFS_MAG_HI = 5;
  localparam int ACU_OFS_MAG_LO = 3;
  localparam logic [7:0] ACU_PIN_SEL_MASK = 8'h7F;
  localparam logic [7:0] ACU_OFS_MASK = 8'hF8;
  localparam logic [7:0] ACU_RESET_VAL = 8'h00;
  // Enables register bits
  localparam int ACU_EN_IRQ = 0;
  localparam int ACU_EN_WAKE = 1;
  // Prescale ratios
  localparam logic [6:0] ACU_DIV_16 = 7'h10;
  localparam logic [6:0] ACU_DIV_4 = 7'h04;
  localparam logic [6:0] ACU_DIV_64 = 7'h40;
  localparam logic [6:0] ACU_DIV_8 = 7'h08;
  localparam logic [2:0] ACU_CH_NONE = 3'h7;
  localparam int ACU_RES_BITS = 10;
  localparam int ACU_CLKS_PER_BIT = 1;
  localparam logic [11:0] ACU_CONV_VECTOR = 12'h00C;
  typedef enum logic [1:0] {ACU_IDLE, ACU_SAMPLE, ACU_BITS, ACU_DONE} acu_state_e;
endpackage

// >>> hdl/acu_prescaler.sv
`timescale 1ns/10ps
module acu_prescaler
  import acu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [1:0] i_rate,
  output logic o_tick
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [6:0] ratio;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    case (i_rate)
      2'b00: ratio = ACU_DIV_16;
      2'b01: ratio = ACU_DIV_4;
      2'b10: ratio = ACU_DIV_64;
      default: ratio = ACU_DIV_8;
    endcase
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!i_run) begin
      cnt_next = 7'h00;
    end else if (cnt_reg >= ratio - 7'h01) begin
      cnt_next = 7'h00;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;
endmodule

// >>> tb/acu_checker.sv
`timescale 1ns/10ps
module acu_checker
  import acu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_timer_clk_en,
  input wire logic i_comparator_out_en,
  input wire logic [9:0] o_dac_code,
  input wire logic o_sample,
  input wire logic [6:0] o_pin_analog,
  input wire logic [2:0] o_mux_sel,
  input wire logic o_mux_valid,
  input wire logic o_ref_from_pin,
  input wire logic o_ref_power,
  input wire logic [1:0] o_pin5_func,
  input wire logic [1:0] o_pin4_func,
  input wire logic o_irq,
  input wire logic [11:0] o_irq_vector,
  input wire logic o_wake
);
  logic [7:0] wd_reg;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) wd_reg <= 8'h00;
    else wd_reg <= i_wdata;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  chk_pin_rd_zero: assert property ($past(i_rd) && $past(i_addr) == ACU_ADDR_PIN_SEL
    |-> !o_rdata[7]) else $error("pin select bit 7 read as one");
  chk_ofs_rd_zero: assert property ($past(i_rd) && $past(i_addr) == ACU_ADDR_OFFSET
    |-> o_rdata[2:0] == 3'h0) else $error("offset low bits read nonzero");
  chk_pin_wr: assert property (i_wr && i_addr == ACU_ADDR_PIN_SEL
    |=> o_pin_analog == wd_reg[6:0]) else $error("pin enables not written");
  chk_ctl_wr: assert property (i_wr && i_addr == ACU_ADDR_CONTROL
    |=> {o_ref_from_pin, o_ref_power} == {wd_reg[7], wd_reg[3]}) else $error("ref bits wrong");
  chk_pin5_prio: assert property (o_pin5_func == (i_timer_clk_en ? 2'h3 :
    i_comparator_out_en ? 2'h2 : o_pin_analog[5] ? 2'h1 : 2'h0)) else $error("pin5 priority");
  chk_pin4_prio: assert property ((o_ref_from_pin || i_timer_clk_en)
    |-> o_pin4_func == (o_ref_from_pin ? 2'h1 : 2'h3)) else $error("pin4 priority");
  chk_mux_valid: assert property (o_mux_valid == (o_mux_sel != ACU_CH_NONE))
    else $error("channel valid mismatch");
  chk_sel_frozen: assert property (o_irq && i_wr && i_addr == ACU_ADDR_CONTROL
    |=> $stable(o_mux_sel)) else $error("channel changed while done");
  chk_irq_vector: assert property (o_irq |-> o_irq_vector == ACU_CONV_VECTOR)
    else $error("wrong converter vector");
  chk_first_trial: assert property ($fell(o_sample) && $past(o_ref_power)
    |-> o_dac_code == 10'h200) else $error("first trial code not msb");
  cov_done: cover property ($rose(o_irq));
  cov_wake: cover property ($rose(o_wake));
  cov_frozen: cover property (o_irq && i_wr && i_addr == ACU_ADDR_CONTROL);
  cov_abort: cover property ($fell(o_sample) && !$past(o_ref_power));
endmodule

bind acu_adc_control acu_checker u_chk (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .i_timer_clk_en, .i_comparator_out_en, .o_dac_code, .o_sample, .o_pin_analog,
  .o_mux_sel, .o_mux_valid, .o_ref_from_pin, .o_ref_power, .o_pin5_func, .o_pin4_func,
  .o_irq, .o_irq_vector, .o_wake);

// >>> tb/acu_analog_model.sv
`timescale 1ns/10ps
module acu_analog_model (
  input wire logic [9:0] i_dac_code,
  input wire logic [10:0] i_vin_x2,
  output logic o_cmp_gt
);
  // Input sits half a step above a code, so the comparator never meets a tie
  assign o_cmp_gt = i_vin_x2 > {i_dac_code, 1'b0};
endmodule

// >>> tb/acu_adc_control_tb.sv
`timescale 1ns/10ps
module acu_adc_control_tb;
  import acu_pkg::*;
  localparam int CPB = 2;
  localparam int DIV [4] = '{16, 4, 64, 8};
  localparam logic [7:0] OFS [4] = '{8'h00, 8'hE8, 8'hB8, 8'h78};
  logic i_clk_sys = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_cmp_gt, pend = 0;
  logic i_timer_clk_en = 0, i_comparator_out_en = 0, i_sleep = 0;
  logic [3:0] i_addr = 0;
  logic [7:0] i_wdata = 0, o_rdata;
  logic [10:0] vin_x2 = 0;
  logic [9:0] o_dac_code;
  logic o_sample, o_mux_valid, o_ref_from_pin, o_ref_power, o_irq, o_wake;
  logic [6:0] o_pin_analog;
  logic [2:0] o_mux_sel;
  logic [1:0] o_pin5_func, o_pin4_func;
  logic [11:0] o_irq_vector;
  logic [7:0] exp_q[$];
  int n_fail = 0, cmp_count = 0, cyc = 0, seed = 32'h1BA9;
  acu_adc_control #(.CLKS_PER_BIT(CPB)) dut (.i_clk_sys, .i_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_cmp_gt, .i_timer_clk_en, .i_comparator_out_en, .i_sleep, .o_dac_code,
    .o_sample, .o_pin_analog, .o_mux_sel, .o_mux_valid, .o_ref_from_pin, .o_ref_power,
    .o_pin5_func, .o_pin4_func, .o_irq, .o_irq_vector, .o_wake);
  acu_analog_model u_ana (.i_dac_code(o_dac_code), .i_vin_x2(vin_x2), .o_cmp_gt(i_cmp_gt));
  initial begin
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  function automatic logic [9:0] corr(input logic [9:0] v, input logic [7:0] o);
    int r;
    r = o[6] ? int'(v) + int'(o[5:3]) : int'(v) - int'(o[5:3]);
    if (!o[7]) r = int'(v);
    if (r < 0) r = 0;
    if (r > 1023) r = 1023;
    return r[9:0];
  endfunction
  // Read results land one cycle after the strobe; oldest note is compared then
  always @(posedge i_clk_sys) begin
    if (pend) check(16'(o_rdata), 16'(exp_q.pop_front()));
    pend <= i_rd;
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    logic [9:0] v;
    logic [7:0] ctl;
    int n;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    for (int a = 3; a < 15; a++) rd(a[3:0], 8'h00);
    $display("reset values done");
    wr(ACU_ADDR_PIN_SEL, 8'hFF);
    rd(ACU_ADDR_PIN_SEL, 8'h7F);
    check(16'(o_pin_analog), 16'h007F);
    wr(ACU_ADDR_OFFSET, 8'hFF);
    rd(ACU_ADDR_OFFSET, 8'hF8);
    wr(ACU_ADDR_PIN_SEL, 8'h20);
    for (int i = 0; i < 8; i++) begin
      i_timer_clk_en <= i[0];
      i_comparator_out_en <= i[1];
      wr(ACU_ADDR_CONTROL, {i[2], 7'h00});
      check(16'(o_pin5_func), i[0] ? 16'h3 : i[1] ? 16'h2 : 16'h1);
      check({o_ref_from_pin, 13'h0, o_pin4_func}, i[2] ? 16'h8001 : i[0] ? 16'h3 : 16'h0);
    end
    $display("pin priority done");
    for (int c = 0; c < 8; c++) begin
      wr(ACU_ADDR_CONTROL, 8'(c));
      check({o_mux_valid, 12'h0, o_mux_sel}, {c != 7, 12'h0, c[2:0]});
    end
    $display("channel select done");
    wr(ACU_ADDR_ENABLES, 8'h03);
    for (int r = 0; r < 4; r++) begin
      v = 10'($random(seed));
      if (r == 2) v = 10'h003;
      vin_x2 <= {v, 1'b1};
      i_sleep <= r[0];
      wr(ACU_ADDR_OFFSET, OFS[r]);
      ctl = {1'b0, r[1:0], 5'h08};
      wr(ACU_ADDR_CONTROL, ctl);
      wr(ACU_ADDR_CONTROL, ctl | 8'h10);
      wr(ACU_ADDR_CONTROL, ctl | 8'h03);
      check(16'(o_mux_sel), 16'h0);
      n = 0;
      while (o_dac_code !== 10'h200 && n < 400) begin
        @(negedge i_clk_sys);
        n++;
      end
      n = 0;
      while (o_dac_code === 10'h200 && n < 400) begin
        @(negedge i_clk_sys);
        n++;
      end
      check(16'(n), 16'(DIV[r] * CPB));
      n = 0;
      while (o_irq !== 1'b1 && n < 3000) begin
        @(negedge i_clk_sys);
        n++;
      end
      check({2'h0, o_irq, o_wake, o_irq_vector}, {2'h0, 1'b1, r[0], ACU_CONV_VECTOR});
      @(posedge i_clk_sys);
      wr(ACU_ADDR_CONTROL, ctl | 8'h05);
      check(16'(o_mux_sel), 16'h0);
      v = corr(v, OFS[r]);
      rd(ACU_ADDR_RES_HI, v[9:2]);
      rd(ACU_ADDR_RES_LO, {6'h00, v[1:0]});
      rd(ACU_ADDR_CONTROL, ctl);
      rd(ACU_ADDR_STATUS, 8'h01);
      wr(ACU_ADDR_STATUS, 8'h00);
      $display("conversion %0d done", r);
    end
    wr(ACU_ADDR_CONTROL, 8'h08);
    wr(ACU_ADDR_CONTROL, 8'h18);
    wr(ACU_ADDR_CONTROL, 8'h10);
    repeat (40) @(posedge i_clk_sys);
    check({5'h00, o_sample, o_dac_code}, 16'h0000);
    rd(ACU_ADDR_CONTROL, 8'h10);
    $display("power abort done");
    repeat (2) @(posedge i_clk_sys);
    wrap_up();
  end
endmodule
